// ### design/rst_seq_pkg.sv
// constants, encodings and helpers shared by the reset and low-power sequencer
package rst_seq_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam int CLK_MHZ = 40;
   // device-side hard reset stretch, well past the longest external pulse
   localparam int HARD_HOLD_NS = 3000;
   localparam int SOFT_HOLD_NS = 800;
   // gap between self-refresh command and memory clock stop
   localparam int SR_SETTLE_NS = 200;

   // least time rounded up to whole cycles, never below one
   function automatic int cycles_of(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] HARD_CYC = CNT_W'(cycles_of(HARD_HOLD_NS));
   localparam logic [CNT_W-1:0] SOFT_CYC = CNT_W'(cycles_of(SOFT_HOLD_NS));
   localparam logic [CNT_W-1:0] SR_CYC = CNT_W'(cycles_of(SR_SETTLE_NS));

   ////////////////////////////////////////////////////////////////////////////////
   // register map (byte addresses)
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_RESET_STATUS = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RESET_CONTROL = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_MAP_BASE = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_CONFIG_WORD = 8'h0C;

   // reset_status_reg fields
   localparam int STAT_HARD_BIT = 0;
   localparam int STAT_SOFT_BIT = 1;
   localparam int STAT_POR_BIT = 2;
   localparam int STAT_LP_BIT = 8;
   localparam logic [2:0] STAT_HARD = 3'h1;
   localparam logic [2:0] STAT_SOFT = 3'h2;
   localparam logic [2:0] STAT_POR = 3'h4;

   // reset_control_reg fields
   localparam int CTRL_SOFT_BIT = 0;
   localparam int CTRL_LP_REQ_BIT = 1;
   localparam int CTRL_SR_EN_BIT = 2;

   // config_word clock-mode bits, kept from power-on reset only
   localparam int CW_LBUS_CM_BIT = 1;
   localparam int CW_MEM_CM_BIT = 2;
   localparam logic [31:0] CW_CM_MASK = 32'h0000_0006;

   // reset values
   localparam logic [31:0] MAP_BASE_RST = 32'hFF00_0000;
   localparam logic [31:0] CONFIG_RST = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer states, gray along the power-on and hard reset paths, not the soft or low-power ones
   typedef enum logic [2:0] {
      ST_POR_LOAD = 3'h4,
      ST_RUN = 3'h0,
      ST_HARD_DRIVE = 3'h1,
      ST_HARD_RELEASE = 3'h3,
      ST_CFG_LOAD = 3'h2,
      ST_SOFT_HOLD = 3'h6,
      ST_LP_REFRESH = 3'h7,
      ST_LP_SLEEP = 3'h5
   } seq_state_e;

endpackage

// ### design/reset_pin_sync.sv
// two-flop synchroniser for the active-low reset pins
module reset_pin_sync
   import rst_seq_pkg::*;
#(
   parameter int WIDTH = 2
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // pins in, synchronised out
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_s;

   sync_s q, n;

   always_comb begin
      n.meta = din;
      n.stable = q.meta;
   end

   // idle pins are high, so start from the negated level
   always_ff @(posedge clk) begin
      if (!nrst) begin
         q <= '{meta: '1, stable: '1};
      end else if (ce) begin
         q <= n;
      end
   end

   assign dout = q.stable;

endmodule // reset_pin_sync

// ### design/reset_lp_sequencer.sv
// reset and low-power sequencer: hard, soft and power-on reset, memory self-refresh entry
module reset_lp_sequencer
   import rst_seq_pkg::*;
(
   // clock, reset, enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic we,
   input wire logic re,
   output logic [31:0] rdata,
   // hard_reset_line, active low open drain
   input wire logic hard_reset_line_n_in,
   output logic hard_reset_line_n_out,
   output logic hard_reset_line_n_oe,
   // soft_reset_line, active low open drain
   input wire logic soft_reset_line_n_in,
   output logic soft_reset_line_n_out,
   output logic soft_reset_line_n_oe,
   // configuration word source
   input wire logic [31:0] config_word_in,
   // low-power wake
   input wire logic wake_req,
   // reset outputs to the chip
   output logic mem_ctrl_rst,
   output logic lbus_ctrl_rst,
   output logic masters_rst,
   // memory and bus control
   output logic memory_clock_out_en,
   output logic self_refresh_cmd,
   output logic master_hold,
   // configuration out
   output logic local_bus_clock_mode,
   output logic memory_clock_mode,
   output logic [31:0] internal_map_base
);

   ////////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      seq_state_e st;
      logic [CNT_W-1:0] cnt;
      logic [31:0] cfg;
      logic [31:0] map_base;
      logic [2:0] rst_stat;
      logic sw_soft, lp_req, sr_en;
      logic [31:0] rdata;
      logic hard_oe, soft_oe, mem_rst, lbc_rst, mst_rst, mem_clk_en, sr_cmd, hold;
   } seq_s;

   localparam seq_s SEQ_RST = '{
      st: ST_POR_LOAD, cnt: '0, cfg: CONFIG_RST, map_base: MAP_BASE_RST, rst_stat: STAT_POR,
      sw_soft: 1'b0, lp_req: 1'b0, sr_en: 1'b0, rdata: '0, hard_oe: 1'b0, soft_oe: 1'b0,
      mem_rst: 1'b1, lbc_rst: 1'b1, mst_rst: 1'b1, mem_clk_en: 1'b1, sr_cmd: 1'b0, hold: 1'b0
   };

   seq_s q, n;
   logic hard_sync_n;
   logic soft_sync_n;
   logic hard_seen;

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   // sync hard and soft pins
   reset_pin_sync #(
      .WIDTH(2)
   ) u_pin_sync (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .din({hard_reset_line_n_in, soft_reset_line_n_in}),
      .dout({hard_sync_n, soft_sync_n})
   );

   // hard reset may interrupt any settled state, never its own sequence
   assign hard_seen = !hard_sync_n && (q.st == ST_RUN || q.st == ST_SOFT_HOLD ||
                                       q.st == ST_LP_REFRESH || q.st == ST_LP_SLEEP);

   ////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      n = q;
      n.sr_cmd = 1'b0;
      n.rdata = '0;

      if (re) begin
         unique case (addr)
            ADDR_RESET_STATUS: begin
               n.rdata[2:0] = q.rst_stat;
               n.rdata[STAT_LP_BIT] = (q.st == ST_LP_SLEEP);
            end
            ADDR_RESET_CONTROL: begin
               n.rdata[CTRL_SOFT_BIT] = q.sw_soft;
               n.rdata[CTRL_LP_REQ_BIT] = q.lp_req;
               n.rdata[CTRL_SR_EN_BIT] = q.sr_en;
            end
            ADDR_MAP_BASE: n.rdata = q.map_base;
            ADDR_CONFIG_WORD: n.rdata = q.cfg;
            default: n.rdata = '0;
         endcase
      end

      // writes first, so hardware events below win over them
      if (we) begin
         unique case (addr)
            ADDR_RESET_STATUS: n.rst_stat = q.rst_stat & ~wdata[2:0];
            ADDR_RESET_CONTROL: begin
               n.sw_soft = wdata[CTRL_SOFT_BIT];
               n.lp_req = wdata[CTRL_LP_REQ_BIT];
               n.sr_en = wdata[CTRL_SR_EN_BIT];
            end
            ADDR_MAP_BASE: n.map_base = wdata;
            default: n.map_base = q.map_base;
         endcase
      end

      if (hard_seen) begin
         n.st = ST_HARD_DRIVE;
         n.cnt = HARD_CYC - CNT_W'(1);
         n.hard_oe = 1'b1;
         n.soft_oe = 1'b0;
         n.mem_rst = 1'b1;
         n.lbc_rst = 1'b1;
         n.mst_rst = 1'b1;
         n.map_base = MAP_BASE_RST;
         n.rst_stat = STAT_HARD;
         n.sw_soft = 1'b0;
         n.lp_req = 1'b0;
         n.sr_en = 1'b0;
         n.mem_clk_en = 1'b1;
         n.hold = 1'b0;
      end else begin
         unique case (q.st)
            ST_POR_LOAD: begin
               n.cfg = config_word_in;
               n.mem_rst = 1'b0;
               n.lbc_rst = 1'b0;
               n.mst_rst = 1'b0;
               n.st = ST_RUN;
            end
            ST_RUN: begin
               if (!soft_sync_n || q.sw_soft) begin
                  n.st = ST_SOFT_HOLD;
                  n.cnt = SOFT_CYC - CNT_W'(1);
                  n.mst_rst = 1'b1;
                  n.soft_oe = 1'b1;
                  n.sw_soft = 1'b0;
                  n.rst_stat = STAT_SOFT;
               end else if (q.lp_req) begin
                  n.st = ST_LP_REFRESH;
                  n.cnt = SR_CYC - CNT_W'(1);
                  n.sr_cmd = q.sr_en;
                  n.hold = 1'b1;
               end
            end
            ST_SOFT_HOLD: begin
               if (q.cnt != '0) begin
                  n.cnt = q.cnt - CNT_W'(1);
               end else begin
                  n.soft_oe = 1'b0;
                  // own drive must be off and the pin seen high again
                  if (!q.soft_oe && soft_sync_n) begin
                     n.mst_rst = 1'b0;
                     n.st = ST_RUN;
                  end
               end
            end
            ST_HARD_DRIVE: begin
               if (q.cnt != '0) begin
                  n.cnt = q.cnt - CNT_W'(1);
               end else begin
                  n.hard_oe = 1'b0;
                  n.st = ST_HARD_RELEASE;
               end
            end
            ST_HARD_RELEASE: begin
               // a source still holding the line keeps us here
               if (hard_sync_n) begin
                  n.st = ST_CFG_LOAD;
               end
            end
            ST_CFG_LOAD: begin
               n.cfg = (config_word_in & ~CW_CM_MASK) | (q.cfg & CW_CM_MASK);
               n.mem_rst = 1'b0;
               n.lbc_rst = 1'b0;
               n.mst_rst = 1'b0;
               n.st = ST_RUN;
            end
            ST_LP_REFRESH: begin
               // bus requests stay held off through the clock stop and sleep, until wake
               if (q.cnt != '0) begin
                  n.cnt = q.cnt - CNT_W'(1);
               end else begin
                  n.mem_clk_en = 1'b0;
                  n.st = ST_LP_SLEEP;
               end
            end
            ST_LP_SLEEP: begin
               if (wake_req) begin
                  n.mem_clk_en = 1'b1;
                  n.hold = 1'b0;
                  n.lp_req = 1'b0;
                  n.st = ST_RUN;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         q <= SEQ_RST;
      end else if (ce) begin
         q <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign rdata = q.rdata;
   assign hard_reset_line_n_out = 1'b0;
   assign hard_reset_line_n_oe = q.hard_oe;
   assign soft_reset_line_n_out = 1'b0;
   assign soft_reset_line_n_oe = q.soft_oe;
   assign mem_ctrl_rst = q.mem_rst;
   assign lbus_ctrl_rst = q.lbc_rst;
   assign masters_rst = q.mst_rst;
   assign memory_clock_out_en = q.mem_clk_en;
   assign self_refresh_cmd = q.sr_cmd;
   assign master_hold = q.hold;
   assign local_bus_clock_mode = q.cfg[CW_LBUS_CM_BIT];
   assign memory_clock_mode = q.cfg[CW_MEM_CM_BIT];
   assign internal_map_base = q.map_base;
   ////////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_hard_sync;
      (ce && q.st == ST_RUN && !hard_sync_n) |=> (q.st == ST_HARD_DRIVE);
   endproperty
   a_hard_sync: assert property (p_hard_sync) else $error("hard reset not taken from run");

   property p_hard_stretch;
      $rose(q.st == ST_HARD_DRIVE) |-> q.hard_oe [*8];
   endproperty
   a_hard_stretch: assert property (p_hard_stretch) else $error("hard reset drive too short");

   property p_hard_negate;
      $fell(q.hard_oe) |-> ($past(q.cnt) == '0) && (q.st == ST_HARD_RELEASE);
   endproperty
   a_hard_negate: assert property (p_hard_negate) else $error("hard reset released early");

   property p_cfg_reload;
      (ce && q.st == ST_CFG_LOAD) |=>
         ((q.cfg & ~CW_CM_MASK) == ($past(config_word_in) & ~CW_CM_MASK)) &&
         ((q.cfg & CW_CM_MASK) == ($past(q.cfg) & CW_CM_MASK));
   endproperty
   a_cfg_reload: assert property (p_cfg_reload) else $error("config word not reloaded");

   property p_soft_spares;
      (q.st == ST_SOFT_HOLD) |-> !q.mem_rst && !q.lbc_rst && q.mst_rst;
   endproperty
   a_soft_spares: assert property (p_soft_spares) else $error("soft reset wrong targets");

   property p_soft_at_once;
      (ce && q.st == ST_RUN && hard_sync_n && (!soft_sync_n || q.sw_soft)) |=>
         (q.st == ST_SOFT_HOLD) && q.mst_rst;
   endproperty
   a_soft_at_once: assert property (p_soft_at_once) else $error("masters not reset at once");

   property p_soft_keeps_cfg;
      (q.st == ST_SOFT_HOLD && hard_sync_n && !we) |=> $stable(q.map_base) && $stable(q.cfg);
   endproperty
   a_soft_keeps_cfg: assert property (p_soft_keeps_cfg) else $error("soft reset changed config");

   property p_map_default;
      $rose(q.st == ST_HARD_DRIVE) |-> (q.map_base == MAP_BASE_RST);
   endproperty
   a_map_default: assert property (p_map_default) else $error("map base not defaulted");

   property p_status_kind;
      $rose(q.st == ST_SOFT_HOLD) |-> (q.rst_stat == STAT_SOFT);
   endproperty
   a_status_kind: assert property (p_status_kind) else $error("status misses soft reset");

   property p_refresh_first;
      $fell(q.mem_clk_en) |-> ($past(q.st) == ST_LP_REFRESH) && q.hold;
   endproperty
   a_refresh_first: assert property (p_refresh_first) else $error("clock stopped early");

   property p_refresh_cmd;
      $rose(q.st == ST_LP_REFRESH) |-> (q.sr_cmd == q.sr_en) && q.mem_clk_en;
   endproperty
   a_refresh_cmd: assert property (p_refresh_cmd) else $error("no self-refresh command");

   property p_por_capture;
      (ce && q.st == ST_POR_LOAD) |=> (q.cfg == $past(config_word_in)) && !q.mst_rst;
   endproperty
   a_por_capture: assert property (p_por_capture) else $error("power-on word not captured");

   c_hard: cover property ($fell(q.hard_oe));
   c_soft: cover property ($fell(q.st == ST_SOFT_HOLD));
   c_sleep: cover property ($rose(q.st == ST_LP_SLEEP));
   c_wake: cover property ($rose(q.mem_clk_en));

endmodule // reset_lp_sequencer

// ### test/reset_source_model.sv
// board-side reset source: open-drain pull on the hard reset line, soft pull held off
module reset_source_model (
   // clock
   input wire logic clk,
   // command from the bench
   input wire logic start,
   input wire logic [7:0] pulse_cyc,
   // open-drain pulls, high = pulling the line low
   output logic hard_pull,
   output logic soft_pull
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] cnt_q;

   always @(posedge clk) begin
      if (start) begin
         cnt_q <= (pulse_cyc < 8'd33) ? 8'd33 : (pulse_cyc > 8'd99) ? 8'd99 : pulse_cyc;
      end else if (cnt_q != 8'd0) begin
         cnt_q <= cnt_q - 8'd1;
      end
   end

   initial cnt_q = 8'd0;
   assign hard_pull = (cnt_q != 8'd0);
   assign soft_pull = 1'b0;
endmodule // reset_source_model

// ### test/tb_top.sv
// self-checking bench for the reset and low-power sequencer
module tb_top
   import rst_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, nrst, ce, we, re, wake_req, hard_start;
   logic pend = 1'b0;
   logic [7:0] addr;
   logic [31:0] wdata, config_word_in, rdata, cw0, cw1, cw2, mb;
   logic hard_out, hard_oe, soft_out, soft_oe, hard_pull, soft_pull;
   logic mem_rst, lbus_rst, masters_rst, mclk_en, sr_cmd, hold, lbus_cm, mem_cm;
   logic [31:0] map_base;
   logic [31:0] exp_q[$];
   string name_q[$];
   int mismatches = 0;
   int tests_run = 0;

   reset_lp_sequencer dut_u (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
      .we(we), .re(re), .rdata(rdata), .hard_reset_line_n_in(~(hard_oe | hard_pull)),
      .hard_reset_line_n_out(hard_out), .hard_reset_line_n_oe(hard_oe),
      .soft_reset_line_n_in(~(soft_oe | soft_pull)), .soft_reset_line_n_out(soft_out),
      .soft_reset_line_n_oe(soft_oe), .config_word_in(config_word_in), .wake_req(wake_req),
      .mem_ctrl_rst(mem_rst), .lbus_ctrl_rst(lbus_rst), .masters_rst(masters_rst),
      .memory_clock_out_en(mclk_en), .self_refresh_cmd(sr_cmd), .master_hold(hold),
      .local_bus_clock_mode(lbus_cm), .memory_clock_mode(mem_cm),
      .internal_map_base(map_base));

   reset_source_model src_u (.clk(clk), .start(hard_start), .pulse_cyc(8'd50),
      .hard_pull(hard_pull), .soft_pull(soft_pull));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // comparison, verdict and waits
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   function automatic logic probe(input int k);
      case (k)
         0: return hard_oe;
         1: return masters_rst;
         2: return mem_rst;
         default: return mclk_en;
      endcase
   endfunction

   // bounded wait on one of the probed outputs
   task automatic wait_lvl(input int k, input logic v, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         @(posedge clk);
         #1;
         if (probe(k) === v) return;
      end
      mismatches++;
      $display("mismatch wait_%0d expected %b seen timeout", k, v);
      end_of_test();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // register bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      exp_q.push_back(e);
      name_q.push_back(n);
      @(posedge clk);
      re <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe; looked at mid-cycle
   always @(negedge clk) begin
      if (pend) begin
         if (exp_q.size() == 0) begin
            chk("read_unexpected", 32'h0, 32'h1);
         end else begin
            chk(name_q.pop_front(), exp_q.pop_front(), rdata);
         end
      end
      pend <= re;
   end

   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      $display("mismatch watchdog expected done seen timeout");
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   initial begin
      void'($urandom(68528));
      cw0 = $urandom;
      mb = $urandom;
      cw1 = $urandom;
      {nrst, ce, we, re, wake_req, hard_start} = 6'b010000;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      config_word_in = cw0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("por_resets", {mem_rst, lbus_rst, masters_rst}, 3'b000);
      chk("por_modes", {lbus_cm, mem_cm}, {cw0[CW_LBUS_CM_BIT], cw0[CW_MEM_CM_BIT]});
      rd(ADDR_RESET_STATUS, 32'(STAT_POR), "por_status");
      rd(ADDR_CONFIG_WORD, cw0, "por_config");
      rd(ADDR_MAP_BASE, MAP_BASE_RST, "por_base");
      wr(ADDR_MAP_BASE, mb);
      // ce low freezes all state, so this write is lost
      @(posedge clk);
      ce <= 1'b0;
      wr(ADDR_MAP_BASE, ~mb);
      ce <= 1'b1;
      rd(ADDR_MAP_BASE, mb, "frozen_base");
      // soft request by software, deliberate, to exercise the device side
      wr(ADDR_RESET_CONTROL, 32'h1 << CTRL_SOFT_BIT);
      wait_lvl(1, 1'b1, 3);
      chk("soft_spared", {mem_rst, lbus_rst, soft_oe}, 3'b001);
      chk("soft_level", soft_out, 32'h0);
      repeat (20) @(posedge clk);
      #1;
      chk("soft_held", {masters_rst, mem_rst, lbus_rst}, 3'b100);
      wait_lvl(1, 1'b0, 60);
      chk("soft_after", {mem_rst, lbus_rst}, 2'b00);
      chk("soft_base_port", map_base, mb);
      rd(ADDR_MAP_BASE, mb, "soft_base");
      rd(ADDR_CONFIG_WORD, cw0, "soft_config");
      rd(ADDR_RESET_STATUS, 32'(STAT_SOFT), "soft_status");
      // reset status cleared first, then low power with self-refresh
      wr(ADDR_RESET_STATUS, 32'h0000_0007);
      wr(ADDR_RESET_CONTROL, (32'h1 << CTRL_LP_REQ_BIT) | (32'h1 << CTRL_SR_EN_BIT));
      lp_check();
      // hard reset from the board, config word source changed meanwhile
      @(posedge clk);
      config_word_in <= cw1;
      hard_start <= 1'b1;
      @(posedge clk);
      hard_start <= 1'b0;
      wait_lvl(0, 1'b1, 6);
      chk("hard_resets", {mem_rst, lbus_rst, masters_rst}, 3'b111);
      chk("hard_base_port", map_base, MAP_BASE_RST);
      repeat (55) @(posedge clk);
      #1;
      chk("hard_stretch", {hard_pull, hard_oe}, 2'b01);
      chk("hard_level", hard_out, 32'h0);
      wait_lvl(0, 1'b0, 130);
      wait_lvl(2, 1'b0, 10);
      chk("hard_after", {lbus_rst, masters_rst}, 2'b00);
      chk("hard_modes", {lbus_cm, mem_cm}, {cw0[CW_LBUS_CM_BIT], cw0[CW_MEM_CM_BIT]});
      rd(ADDR_RESET_STATUS, 32'(STAT_HARD), "hard_status");
      rd(ADDR_MAP_BASE, MAP_BASE_RST, "hard_base");
      rd(ADDR_CONFIG_WORD, (cw1 & ~CW_CM_MASK) | (cw0 & CW_CM_MASK), "hard_config");
      // refused places
      wr(ADDR_CONFIG_WORD, ~cw1);
      rd(ADDR_CONFIG_WORD, (cw1 & ~CW_CM_MASK) | (cw0 & CW_CM_MASK), "ro_config");
      rd(8'h10, 32'h0000_0000, "unmapped");
      // clock modes changed, so a power-on reset is applied
      cw2 = ($urandom & ~CW_CM_MASK) | (~cw0 & CW_CM_MASK);
      config_word_in <= cw2;
      nrst <= 1'b0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("por2_modes", {lbus_cm, mem_cm}, {cw2[CW_LBUS_CM_BIT], cw2[CW_MEM_CM_BIT]});
      rd(ADDR_CONFIG_WORD, cw2, "por2_config");
      rd(ADDR_MAP_BASE, MAP_BASE_RST, "por2_base");
      rd(ADDR_RESET_STATUS, 32'(STAT_POR), "por2_status");
      repeat (3) @(posedge clk);
      chk("reads_left", 32'(exp_q.size()), 32'h0);
      end_of_test();
   end

   // self-refresh must lead the memory clock stop by the settle time
   task automatic lp_check();
      int i, sr_at, off_at;
      sr_at = -1;
      off_at = -1;
      for (i = 0; i < 30; i++) begin
         @(posedge clk);
         #1;
         if (sr_cmd === 1'b1 && sr_at < 0) sr_at = i;
         if (mclk_en === 1'b0 && off_at < 0) off_at = i;
      end
      chk("sr_seen", 32'(sr_at >= 0), 32'h1);
      chk("sr_settle", 32'(off_at - sr_at), 32'(SR_CYC));
      chk("sleep_hold", {hold, mclk_en}, 2'b10);
      rd(ADDR_RESET_STATUS, 32'h1 << STAT_LP_BIT, "sleep_status");
      @(posedge clk);
      wake_req <= 1'b1;
      @(posedge clk);
      wake_req <= 1'b0;
      wait_lvl(3, 1'b1, 4);
      @(posedge clk);
      #1;
      chk("wake_hold", hold, 32'h0);
   endtask
endmodule // tb_top
